//--- rtl/mptrk_pkg.sv
// constants shared by the phy connection tracker and its channel logic
// assumes a 32-bit ahb-lite register bus with word-aligned registers
package mptrk_pkg;
    localparam int          MPTRK_DATA_W    = 32;
    localparam int          MPTRK_ADDR_W    = 8;
    localparam int          MPTRK_PHY_AW    = 5;
    localparam int          MPTRK_NCHAN     = 2;
    // register byte offsets
    localparam logic [7:0]  OFS_STATE_VEC   = 8'h00;
    localparam logic [7:0]  OFS_RAW_EVENT   = 8'h04;
    localparam logic [7:0]  OFS_MASK_EVENT  = 8'h08;
    localparam logic [7:0]  OFS_PHY_SEL0    = 8'h0C;
    localparam logic [7:0]  OFS_PHY_SEL1    = 8'h10;
    // user_phy_select field layout
    localparam int          SEL_ADDR_LSB    = 0;
    localparam int          SEL_IRQ_EN_BIT  = 7;
    localparam logic [31:0] SEL_WR_MASK     = 32'h0000_009F;
    // values after reset, then the ahb-lite nonseq transfer code
    localparam logic [31:0] RST_STATE_VEC   = 32'h0000_0000;
    localparam logic [31:0] RST_PHY_SEL     = 32'h0000_0000;
    localparam logic        RST_EVENT       = 1'b0;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
endpackage : mptrk_pkg

//--- rtl/mptrk_chan.sv
// one change-event channel: raw and enable-masked w1c event bits
// assumes the tracker feeds it the status-read strobe and current vector
module mptrk_chan
    import mptrk_pkg::*;
(
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    stat_done,
    input  wire logic [MPTRK_PHY_AW-1:0] stat_phy_addr,
    input  wire logic                    stat_new_state,
    input  wire logic [MPTRK_PHY_AW-1:0] sel_addr,
    input  wire logic                    sel_irq_en,
    input  wire logic                    old_state,
    input  wire logic                    event_clr,
    output logic                         raw_event,
    output logic                         raw_event_next,
    output logic                         masked_event
);
    logic raw_reg;
    logic hit;
    logic set_event;

    // a change is only seen when the selected phy was just read
    always_comb begin
        hit            = stat_done && (stat_phy_addr == sel_addr);
        set_event      = hit && (stat_new_state != old_state);
        // set wins over a clear in the same cycle, so no event is lost
        raw_event_next = set_event | (raw_reg & ~event_clr);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_reg <= RST_EVENT;
        end else begin
            raw_reg <= raw_event_next;
        end
    end

    assign raw_event    = raw_reg;
    assign masked_event = raw_reg & sel_irq_en;

    a_event_set: assert property (
        @(posedge hclk) disable iff (!hresetn)
        set_event |=> raw_event)
        else $error("change on selected phy did not raise raw event");
    a_event_quiet: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !raw_event && !(hit && stat_new_state != old_state)
        |=> !raw_event)
        else $error("raw event set without a state change");
    a_w1c_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        event_clr && !set_event |=> !raw_event)
        else $error("write one did not clear the event");
    a_w0_keep: assert property (
        @(posedge hclk) disable iff (!hresetn)
        raw_event && !event_clr |=> raw_event)
        else $error("event lost without a write one");
    a_mask_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        masked_event |-> raw_event && sel_irq_en)
        else $error("masked event without pending event and enable");
endmodule : mptrk_chan

//--- rtl/mptrk_tracker.sv
// phy connection tracker: per-address state vector, two change channels
// assumes an ahb-lite master, single slave, and a frame engine that
// pulses stat_done for one cycle when a generic status read completes
//
// Added by the designer: the address map and the AHB-Lite slave port.
module mptrk_tracker
    import mptrk_pkg::*;
(
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    input  wire logic                         stat_done,
    input  wire logic [mptrk_pkg::MPTRK_PHY_AW-1:0] stat_phy_addr,
    input  wire logic                         stat_ack,
    input  wire logic                         stat_link_up,
    output logic                              change_irq
);
    import mptrk_pkg::*;

    logic [31:0]             state_vec_reg;
    logic [31:0]             state_vec_next;
    logic [31:0]             sel_reg   [MPTRK_NCHAN];
    logic [31:0]             sel_next  [MPTRK_NCHAN];
    logic                    wr_pend_reg;
    logic                    wr_pend_next;
    logic [MPTRK_ADDR_W-1:0] wr_addr_reg;
    logic [MPTRK_ADDR_W-1:0] wr_addr_next;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic                    addr_phase;
    logic                    stat_new_state;
    logic [MPTRK_NCHAN-1:0]  raw_event;
    logic [MPTRK_NCHAN-1:0]  raw_event_next;
    logic [MPTRK_NCHAN-1:0]  masked_event;
    logic [MPTRK_NCHAN-1:0]  event_clr;

    // zero wait state slave; every answer is okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    assign addr_phase     = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign stat_new_state = stat_ack && stat_link_up;

    // bus address phase capture; write data lands in the data phase
    always_comb begin
        wr_pend_next = addr_phase && hwrite;
        wr_addr_next = wr_pend_next ? haddr[MPTRK_ADDR_W-1:0] : wr_addr_reg;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
        end
    end

    // state vector follows status reads only; the bus has no write path
    always_comb begin
        state_vec_next = state_vec_reg;
        if (stat_done) begin
            state_vec_next[stat_phy_addr] = stat_new_state;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_vec_reg <= RST_STATE_VEC;
        end else begin
            state_vec_reg <= state_vec_next;
        end
    end

    // per-channel select registers and event logic
    genvar n;
    generate
        for (n = 0; n < MPTRK_NCHAN; n++) begin : g_chan
            localparam logic [7:0] SEL_OFS =
                (n == 0) ? OFS_PHY_SEL0 : OFS_PHY_SEL1;

            always_comb begin
                sel_next[n] = sel_reg[n];
                if (wr_pend_reg && wr_addr_reg == SEL_OFS) begin
                    sel_next[n] = hwdata & SEL_WR_MASK;
                end
                // both event registers clear the same pending bit
                event_clr[n] = wr_pend_reg && hwdata[n] &&
                    (wr_addr_reg == OFS_RAW_EVENT ||
                     wr_addr_reg == OFS_MASK_EVENT);
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sel_reg[n] <= RST_PHY_SEL;
                end else begin
                    sel_reg[n] <= sel_next[n];
                end
            end

            mptrk_chan u_chan (
                .hclk           (hclk),
                .hresetn        (hresetn),
                .stat_done      (stat_done),
                .stat_phy_addr  (stat_phy_addr),
                .stat_new_state (stat_new_state),
                .sel_addr       (sel_reg[n][SEL_ADDR_LSB +: MPTRK_PHY_AW]),
                .sel_irq_en     (sel_reg[n][SEL_IRQ_EN_BIT]),
                .old_state      (state_vec_reg[
                                 sel_reg[n][SEL_ADDR_LSB +: MPTRK_PHY_AW]]),
                .event_clr      (event_clr[n]),
                .raw_event      (raw_event[n]),
                .raw_event_next (raw_event_next[n]),
                .masked_event   (masked_event[n])
            );

            // the tracker's own view of a change on select n's phy,
            // kept apart from the channel so a wiring slip shows up
            sequence s_sel_flip;
                stat_done &&
                (stat_phy_addr == sel_reg[n][SEL_ADDR_LSB +: MPTRK_PHY_AW]) &&
                ((stat_ack && stat_link_up) != state_vec_reg[stat_phy_addr]);
            endsequence

            a_sel_flip: assert property (
                @(posedge hclk) disable iff (!hresetn)
                s_sel_flip |=> raw_event[n])
                else $error("change on selected phy left raw event low");
            // a status read in the same cycle may set the bit again
            a_mask_w1c: assert property (
                @(posedge hclk) disable iff (!hresetn)
                wr_pend_reg && hwdata[n] && !stat_done &&
                (wr_addr_reg == OFS_MASK_EVENT) |=> !raw_event[n])
                else $error("write one to masked events did not clear");
        end
    endgenerate

    assign change_irq = |masked_event;

    // read data taken from next values so a write just ahead is seen
    always_comb begin
        rdata_next = rdata_reg;
        if (addr_phase && !hwrite) begin
            unique case (haddr[MPTRK_ADDR_W-1:0])
                OFS_STATE_VEC:  rdata_next = state_vec_next;
                OFS_RAW_EVENT:  rdata_next = {30'h0, raw_event_next};
                OFS_MASK_EVENT: rdata_next = {30'h0,
                    raw_event_next[1] & sel_next[1][SEL_IRQ_EN_BIT],
                    raw_event_next[0] & sel_next[0][SEL_IRQ_EN_BIT]};
                OFS_PHY_SEL0:   rdata_next = sel_next[0];
                OFS_PHY_SEL1:   rdata_next = sel_next[1];
                default:        rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    sequence s_read_ok;
        stat_done && stat_ack && stat_link_up;
    endsequence

    sequence s_read_down;
        stat_done && !(stat_ack && stat_link_up);
    endsequence

    a_link_set: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_read_ok |=> state_vec_reg[$past(stat_phy_addr)])
        else $error("acknowledged link read did not set state bit");
    a_link_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_read_down |=> !state_vec_reg[$past(stat_phy_addr)])
        else $error("failed link read did not clear state bit");
    a_vec_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !stat_done |=> $stable(state_vec_reg))
        else $error("state vector changed without a status read");
    a_one_bit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        stat_done |=> ((state_vec_reg ^ $past(state_vec_reg)) &
            ~(32'h0000_0001 << $past(stat_phy_addr))) == 32'h0)
        else $error("status read changed another address");
    a_rsvd_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite && (haddr[7:0] == OFS_RAW_EVENT ||
        haddr[7:0] == OFS_MASK_EVENT) |=> hrdata[31:2] == 30'h0)
        else $error("reserved event bits read nonzero");
    a_irq_source: assert property (
        @(posedge hclk) disable iff (!hresetn)
        change_irq |-> (raw_event[0] && sel_reg[0][SEL_IRQ_EN_BIT]) ||
                       (raw_event[1] && sel_reg[1][SEL_IRQ_EN_BIT]))
        else $error("interrupt high with no enabled event");
    a_irq_drop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        raw_event == 2'h0 |-> !change_irq)
        else $error("interrupt high after events cleared");
endmodule : mptrk_tracker

//--- verif/mptrk_phy_model.sv
// phy side model: delivers completed generic status reads to the tracker
// assumes the bench calls status_read just after a rising clock edge
module mptrk_phy_model
    import mptrk_pkg::*;
(
    input  wire logic                    hclk,
    output logic                         stat_done,
    output logic [MPTRK_PHY_AW-1:0]      stat_phy_addr,
    output logic                         stat_ack,
    output logic                         stat_link_up
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle until the first frame completes
    initial begin
        stat_done     = 1'b0;
        stat_phy_addr = '0;
        stat_ack      = 1'b0;
        stat_link_up  = 1'b0;
    end
    // a frame may run slow; an absent phy leaves mdio on its pull-up,
    // so its status bits read as ones even though no acknowledge came
    task automatic status_read(input logic [4:0] a, input logic ack,
                               input logic up, input int slow);
        repeat (slow) @(posedge hclk);
        stat_done     <= 1'b1;
        stat_phy_addr <= a;
        stat_ack      <= ack;
        stat_link_up  <= ack ? up : 1'b1;
        @(posedge hclk);
        // outside the pulse the lines carry junk, never the last value
        stat_done     <= 1'b0;
        stat_phy_addr <= ~a;
        stat_ack      <= ~ack;
        stat_link_up  <= ~stat_link_up;
    endtask : status_read
endmodule : mptrk_phy_model

//--- verif/test_mdio_phy_link_tracker.sv
// bench for the phy connection tracker: ahb-lite master tasks and tests
// assumes a zero-wait slave whose hreadyout is fed back as hready
module test_mdio_phy_link_tracker;
    timeunit 1ns;
    timeprecision 1ns;
    import mptrk_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, change_irq, stat_done, stat_ack, stat_up;
    logic [4:0]  stat_addr;
    int          n_mismatch = 0, checks_done = 0;
    // every mapped register, walked once after reset
    logic [7:0]  reg_ofs [5] = '{OFS_STATE_VEC, OFS_RAW_EVENT,
                                 OFS_MASK_EVENT, OFS_PHY_SEL0, OFS_PHY_SEL1};
    always #20 hclk = ~hclk;
    mptrk_tracker DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .stat_done(stat_done),
        .stat_phy_addr(stat_addr), .stat_ack(stat_ack),
        .stat_link_up(stat_up), .change_irq(change_irq));
    mptrk_phy_model u_phy (.hclk(hclk), .stat_done(stat_done),
        .stat_phy_addr(stat_addr), .stat_ack(stat_ack),
        .stat_link_up(stat_up));
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    // one single transfer; read data is taken at the data-phase edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? wd : ~wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        xfer(1'b0, a, 32'h0, d);
        chk($sformatf("reg %h", a), e, d);
    endtask : rdchk
    // irq is looked at once the edge's updates have landed
    task automatic irqchk(input logic e);
        #1 chk("change_irq", {31'h0, e}, {31'h0, change_irq});
    endtask : irqchk
    // status read, then vector, raw and masked events compared
    task automatic phy(input logic [4:0] a, input logic ack, up,
                       input int slow, input logic [31:0] v, r, m);
        u_phy.status_read(a, ack, up, slow);
        rdchk(OFS_STATE_VEC, v);
        rdchk(OFS_RAW_EVENT, r);
        rdchk(OFS_MASK_EVENT, m);
        irqchk(m != 0);
    endtask : phy
    task automatic done(input string n);
        $display("test %s finished, %0d mismatches", n, n_mismatch);
    endtask : done
    // hang guard: tests need well under 2000 cycles
    initial begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (reg_ofs[i])
            rdchk(reg_ofs[i], 32'h0);
        irqchk(1'b0);
        done("reset");
        wr(OFS_PHY_SEL0, 32'hFFFF_FF83);
        rdchk(OFS_PHY_SEL0, 32'h0000_0083);
        wr(OFS_PHY_SEL1, 32'h0000_0005);
        rdchk(OFS_PHY_SEL1, 32'h0000_0005);
        wr(OFS_STATE_VEC, 32'hFFFF_FFFF);
        rdchk(OFS_STATE_VEC, 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        rdchk(8'h40, 32'h0);
        done("registers");
        phy(5'd3, 1'b1, 1'b1, 0, 32'h8, 32'h1, 32'h1);
        wr(OFS_RAW_EVENT, 32'hFFFF_FFFC);
        rdchk(OFS_RAW_EVENT, 32'h1);
        wr(OFS_MASK_EVENT, 32'h1);
        irqchk(1'b0);
        phy(5'd3, 1'b1, 1'b1, 0, 32'h8, 32'h0, 32'h0);
        done("link up");
        phy(5'd5, 1'b1, 1'b1, 3, 32'h28, 32'h2, 32'h0);
        wr(OFS_RAW_EVENT, 32'h2);
        phy(5'd3, 1'b1, 1'b0, 2, 32'h20, 32'h1, 32'h1);
        wr(OFS_RAW_EVENT, 32'h3);
        phy(5'd5, 1'b0, 1'b1, 0, 32'h0, 32'h2, 32'h0);
        phy(5'd31, 1'b1, 1'b1, 1, 32'h8000_0000, 32'h2, 32'h0);
        // a write of zeros must not clear a bit that status reads set
        wr(OFS_STATE_VEC, 32'h0);
        rdchk(OFS_STATE_VEC, 32'h8000_0000);
        done("link down");
        wr(OFS_PHY_SEL1, 32'h0000_0080);
        rdchk(OFS_MASK_EVENT, 32'h2);
        irqchk(1'b1);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(OFS_STATE_VEC, 32'h0);
        rdchk(OFS_RAW_EVENT, 32'h0);
        rdchk(OFS_MASK_EVENT, 32'h0);
        irqchk(1'b0);
        done("second reset");
        summarize();
    end
endmodule : test_mdio_phy_link_tracker
